// *** bst_map.svh ***
// constants of the boundary-scan test port
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

// ---------------------------------------------------------------
// instruction register
// ---------------------------------------------------------------
`define BST_IR_W       3
`define BST_IR_EXTEST  3'h0
`define BST_IR_SAMPLE  3'h4
`define BST_IR_IDCODE  3'h6
`define BST_IR_BYPASS  3'h7
`define BST_IR_CAPT    3'h1

// ---------------------------------------------------------------
// identification register, bit 0 first
// ---------------------------------------------------------------
`define BST_ID_W       32
`define BST_ID_FIXED   1'h1
// maker, part and revision values are arbitrary
`define BST_ID_MAKER   11'h2a5
`define BST_ID_PART    16'h5a3c
`define BST_ID_REV     4'h1
`define BST_ID_WORD    {`BST_ID_REV, `BST_ID_PART, `BST_ID_MAKER, `BST_ID_FIXED}

// ---------------------------------------------------------------
// boundary cells
// ---------------------------------------------------------------
`define BST_BSR_LEN    98
`define BST_PIN_N      8
`define BST_CELL_DIR   16
`define BST_UPD_W      17

`endif

// *** bst_pkg.sv ***
// types of the boundary-scan test port
`include "bst_map.svh"

package bst_pkg;

  // ---------------------------------------------------------------
  // test access controller states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [15:0]
  {
    bst_st_tlr    = 16'h0001,
    bst_st_rti    = 16'h0002,
    bst_st_sel_dr = 16'h0004,
    bst_st_cap_dr = 16'h0008,
    bst_st_sh_dr  = 16'h0010,
    bst_st_ex1_dr = 16'h0020,
    bst_st_pau_dr = 16'h0040,
    bst_st_ex2_dr = 16'h0080,
    bst_st_upd_dr = 16'h0100,
    bst_st_sel_ir = 16'h0200,
    bst_st_cap_ir = 16'h0400,
    bst_st_sh_ir  = 16'h0800,
    bst_st_ex1_ir = 16'h1000,
    bst_st_pau_ir = 16'h2000,
    bst_st_ex2_ir = 16'h4000,
    bst_st_upd_ir = 16'h8000
  } bst_tap_t;

  // selected data register
  typedef enum logic [1:0] {bst_dr_byp = 2'h0, bst_dr_id = 2'h1, bst_dr_bsr = 2'h2} bst_dr_t;

  // pin snapshot handed from the system side
  typedef struct packed
  {
    logic [`BST_PIN_N-1:0] pin_in;
    logic [`BST_PIN_N-1:0] pin_out;
    logic                  drv;
  } bst_snap_t;

endpackage

// *** bst_port.sv ***
// boundary-scan test port: registers, pin cells and clock crossings
`timescale 1ns/10ps
`include "bst_map.svh"

// Summary of operation
// - three-bit instruction register, shifted in low bit first, selects test and register
// - external test places the boundary chain between data in and data out
// - external test captures input pin levels in capture, shifts them out
// - external test drives output pins from the chain at update
// - sample/preload places the boundary chain in path, core pin path untouched
// - sample/preload captures all pin inputs and outputs, shifts them out
// - identification code connects the identification chain, shifted out in shift
// - bypass passes data in to data out with one test clock delay
// - identification word: bit0 one, maker 1-11, part 12-27, revision 28-31
// - identification word leaves low bit first
// - bypass is a single one-bit stage forming the serial path
// - boundary chain is 98 stages, touched only under external test or sample
// - cells 0-15 pair the eight bus pins: even output, odd input
// - cell 16 sets bus pin direction: zero drives, one floats
module bst_port
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output logic                       tdo,
  output logic                       tdo_oe,
  input  wire logic [`BST_PIN_N-1:0] ad_in,
  output logic      [`BST_PIN_N-1:0] ad_out,
  output logic      [`BST_PIN_N-1:0] ad_oe,
  input  wire logic [`BST_PIN_N-1:0] core_ad_out,
  input  wire logic                  core_ad_oe,
  output logic      [`BST_PIN_N-1:0] core_ad_in,
  output logic                       extest_active
);

  // ---------------------------------------------------------------
  // state of both domains
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [`BST_IR_W-1:0]    ir_sh;
    logic [`BST_IR_W-1:0]    ir_cur;
    logic [`BST_ID_W-1:0]    idc;
    logic                    byp;
    logic [`BST_BSR_LEN-1:0] pin_cell_chain;
    logic [`BST_UPD_W-1:0]   upd;
    logic                    upd_tgl;
    logic                    xt;
    logic                    ack_tgl;
    bst_pkg::bst_snap_t      snap;
  } bst_tck_st_t;

  typedef struct packed
  {
    logic                    req_tgl;
    bst_pkg::bst_snap_t      hold;
    logic [`BST_PIN_N-1:0]   pad_out;
    logic                    pad_oe;
    logic                    upd_seen;
    logic [`BST_UPD_W-1:0]   upd_cp;
  } bst_sys_st_t;

  bst_tck_st_t           t_r;
  bst_tck_st_t           t_nxt;
  bst_sys_st_t           s_r;
  bst_sys_st_t           s_nxt;
  bst_pkg::bst_tap_t     tap;
  bst_pkg::bst_dr_t      sel;
  logic [`BST_PIN_N-1:0] ad_in_s;
  logic                  upd_tgl_s;
  logic                  xt_s;
  logic                  ack_s;
  logic                  req_t;

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic bst_pkg::bst_dr_t dr_sel(input logic [`BST_IR_W-1:0] ir);
    case (ir)
      `BST_IR_EXTEST: dr_sel = bst_pkg::bst_dr_bsr;
      `BST_IR_SAMPLE: dr_sel = bst_pkg::bst_dr_bsr;
      `BST_IR_IDCODE: dr_sel = bst_pkg::bst_dr_id;
      default:        dr_sel = bst_pkg::bst_dr_byp;
    endcase
  endfunction

  // pin snapshot into cell order
  function automatic logic [`BST_BSR_LEN-1:0] capt_cells(input bst_pkg::bst_snap_t sn);
    logic [`BST_BSR_LEN-1:0] v;
    v = '0;
    for (int k = 0; k < `BST_PIN_N; k++)
    begin
      v[2*k]   = sn.pin_out[k];
      v[2*k+1] = sn.pin_in[k];
    end
    v[`BST_CELL_DIR] = ~sn.drv;
    capt_cells = v;
  endfunction

  // ---------------------------------------------------------------
  // controller and crossings
  // ---------------------------------------------------------------
  bst_tap_fsm u_fsm
  (
    .tck   (tck),
    .rst_b (rst_b),
    .tms   (tms),
    .state (tap)
  );

  bst_sync #(.W(`BST_PIN_N)) u_sync_pin
  (
    .clk   (clk_sys),
    .rst_b (rst_b),
    .d     (ad_in),
    .q     (ad_in_s)
  );

  bst_sync #(.W(3)) u_sync_to_sys
  (
    .clk   (clk_sys),
    .rst_b (rst_b),
    .d     ({t_r.upd_tgl, t_r.xt, t_r.ack_tgl}),
    .q     ({upd_tgl_s, xt_s, ack_s})
  );

  bst_sync #(.W(1)) u_sync_to_tck
  (
    .clk   (tck),
    .rst_b (rst_b),
    .d     (s_r.req_tgl),
    .q     (req_t)
  );

  // ---------------------------------------------------------------
  // test clock domain
  // ---------------------------------------------------------------
  always_comb
  begin
    t_nxt = t_r;
    sel   = dr_sel(t_r.ir_cur);
    // snapshot word is stable while the request toggle is pending
    if (req_t != t_r.ack_tgl)
    begin
      t_nxt.snap    = s_r.hold;
      t_nxt.ack_tgl = req_t;
    end
    case (tap)
      bst_pkg::bst_st_tlr:
        t_nxt.ir_cur = `BST_IR_IDCODE;
      bst_pkg::bst_st_cap_ir:
        t_nxt.ir_sh = `BST_IR_CAPT;
      bst_pkg::bst_st_sh_ir:
        t_nxt.ir_sh = {tdi, t_r.ir_sh[`BST_IR_W-1:1]};
      bst_pkg::bst_st_upd_ir:
        t_nxt.ir_cur = t_r.ir_sh;
      bst_pkg::bst_st_cap_dr:
        case (sel)
          bst_pkg::bst_dr_id:  t_nxt.idc = `BST_ID_WORD;
          bst_pkg::bst_dr_bsr: t_nxt.pin_cell_chain = capt_cells(t_r.snap);
          default:             t_nxt.byp = 1'h0;
        endcase
      bst_pkg::bst_st_sh_dr:
        case (sel)
          bst_pkg::bst_dr_id:  t_nxt.idc = {tdi, t_r.idc[`BST_ID_W-1:1]};
          bst_pkg::bst_dr_bsr: t_nxt.pin_cell_chain = {tdi, t_r.pin_cell_chain[`BST_BSR_LEN-1:1]};
          default:             t_nxt.byp = tdi;
        endcase
      bst_pkg::bst_st_upd_dr:
        if (sel == bst_pkg::bst_dr_bsr)
        begin
          t_nxt.upd     = t_r.pin_cell_chain[`BST_UPD_W-1:0];
          t_nxt.upd_tgl = ~t_r.upd_tgl;
        end
      default:
        t_nxt.ir_sh = t_r.ir_sh;
    endcase
    t_nxt.xt = (t_nxt.ir_cur == `BST_IR_EXTEST);
  end

  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
    begin
      t_r        <= '0;
      t_r.ir_cur <= `BST_IR_IDCODE;
    end
    else
      t_r <= t_nxt;
  end

  // serial output, only while shifting
  always_comb
  begin
    tdo    = 1'h0;
    tdo_oe = (tap == bst_pkg::bst_st_sh_ir) || (tap == bst_pkg::bst_st_sh_dr);
    if (tap == bst_pkg::bst_st_sh_ir)
      tdo = t_r.ir_sh[0];
    else if (tap == bst_pkg::bst_st_sh_dr)
      case (sel)
        bst_pkg::bst_dr_id:  tdo = t_r.idc[0];
        bst_pkg::bst_dr_bsr: tdo = t_r.pin_cell_chain[0];
        default:             tdo = t_r.byp;
      endcase
  end

  // ---------------------------------------------------------------
  // system clock domain: pin drive and snapshot
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    if (ack_s == s_r.req_tgl)
    begin
      s_nxt.hold.pin_in  = ad_in_s;
      s_nxt.hold.pin_out = s_r.pad_out;
      s_nxt.hold.drv     = s_r.pad_oe;
      s_nxt.req_tgl      = ~s_r.req_tgl;
    end
    // update word held still since its toggle left the test clock side
    if (upd_tgl_s != s_r.upd_seen)
    begin
      s_nxt.upd_cp   = t_r.upd;
      s_nxt.upd_seen = upd_tgl_s;
    end
    if (xt_s)
    begin
      for (int k = 0; k < `BST_PIN_N; k++)
        s_nxt.pad_out[k] = s_r.upd_cp[2*k];
      s_nxt.pad_oe = ~s_r.upd_cp[`BST_CELL_DIR];
    end
    else
    begin
      s_nxt.pad_out = core_ad_out;
      s_nxt.pad_oe  = core_ad_oe;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign ad_out        = s_r.pad_out;
  assign ad_oe         = {`BST_PIN_N{s_r.pad_oe}};
  assign core_ad_in    = ad_in_s;
  assign extest_active = xt_s;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ir_capture: assert property (@(posedge tck) disable iff (!rst_b)
    tap == bst_pkg::bst_st_cap_ir |=> t_r.ir_sh == `BST_IR_CAPT)
    else $error("instruction capture pattern wrong");

  a_ir_update: assert property (@(posedge tck) disable iff (!rst_b)
    tap == bst_pkg::bst_st_upd_ir |=> t_r.ir_cur == $past(t_r.ir_sh))
    else $error("instruction not updated");

  a_bypass_delay: assert property (@(posedge tck) disable iff (!rst_b)
    (tap == bst_pkg::bst_st_sh_dr && sel == bst_pkg::bst_dr_byp)
      ##1 tap == bst_pkg::bst_st_sh_dr |-> tdo == $past(tdi) && tdo_oe)
    else $error("bypass delay is not one clock");

  a_unlisted_byp: assert property (@(posedge tck) disable iff (!rst_b)
    (tap == bst_pkg::bst_st_sh_dr && t_r.ir_cur != `BST_IR_EXTEST
      && t_r.ir_cur != `BST_IR_SAMPLE && t_r.ir_cur != `BST_IR_IDCODE)
      |=> $stable(t_r.idc) && $stable(t_r.pin_cell_chain) && t_r.byp == $past(tdi))
    else $error("unlisted code does not bypass");

  a_id_capture: assert property (@(posedge tck) disable iff (!rst_b)
    tap == bst_pkg::bst_st_cap_dr && t_r.ir_cur == `BST_IR_IDCODE
      |=> t_r.idc[0] == 1'h1 && t_r.idc[11:1] == `BST_ID_MAKER
          && t_r.idc[27:12] == `BST_ID_PART && t_r.idc[31:28] == `BST_ID_REV)
    else $error("identification word misplaced");

  a_id_lsb_first: assert property (@(posedge tck) disable iff (!rst_b)
    tap == bst_pkg::bst_st_sh_dr && sel == bst_pkg::bst_dr_id && tdo == 1'h1
      |=> $past(t_r.idc[0]) == 1'h1 && t_r.idc[30:0] == $past(t_r.idc[31:1]))
    else $error("identification not shifted low bit first");

  a_bsr_capture: assert property (@(posedge tck) disable iff (!rst_b)
    tap == bst_pkg::bst_st_cap_dr && sel == bst_pkg::bst_dr_bsr
      |=> t_r.pin_cell_chain[1] == $past(t_r.snap.pin_in[0])
          && t_r.pin_cell_chain[14] == $past(t_r.snap.pin_out[7])
          && t_r.pin_cell_chain[16] == !$past(t_r.snap.drv))
    else $error("pin cells captured in wrong order");

  a_bsr_shift: assert property (@(posedge tck) disable iff (!rst_b)
    tap == bst_pkg::bst_st_sh_dr && sel == bst_pkg::bst_dr_bsr
      |=> t_r.pin_cell_chain[97] == $past(tdi) && t_r.pin_cell_chain[0] == $past(t_r.pin_cell_chain[1]))
    else $error("boundary chain does not shift");

  a_bsr_guard: assert property (@(posedge tck) disable iff (!rst_b)
    sel != bst_pkg::bst_dr_bsr |=> $stable(t_r.pin_cell_chain))
    else $error("boundary chain touched by other instruction");

  a_extest_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
    xt_s && $stable(s_r.upd_cp) |=> ad_out[7] == $past(s_r.upd_cp[14])
      && ad_oe[0] == !$past(s_r.upd_cp[16]))
    else $error("pins not driven from update cells");

  a_sample_path: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !xt_s |=> ad_out == $past(core_ad_out) && ad_oe[3] == $past(core_ad_oe))
    else $error("core path broken outside external test");

  a_ir_shift: assert property (@(posedge tck) disable iff (!rst_b)
    tap == bst_pkg::bst_st_sh_ir
      |=> t_r.ir_sh == {$past(tdi), $past(t_r.ir_sh[`BST_IR_W-1:1])})
    else $error("instruction not shifted low bit first");

  a_reset_instr: assert property (@(posedge tck) disable iff (!rst_b)
    tap == bst_pkg::bst_st_tlr |=> t_r.ir_cur == `BST_IR_IDCODE)
    else $error("reset instruction is not identification");

  a_bsr_update: assert property (@(posedge tck) disable iff (!rst_b)
    tap == bst_pkg::bst_st_upd_dr && sel == bst_pkg::bst_dr_bsr
      |=> t_r.upd == $past(t_r.pin_cell_chain[`BST_UPD_W-1:0]) && t_r.upd_tgl != $past(t_r.upd_tgl))
    else $error("update cells not loaded from chain");

  a_upd_guard: assert property (@(posedge tck) disable iff (!rst_b)
    tap != bst_pkg::bst_st_upd_dr || sel != bst_pkg::bst_dr_bsr
      |=> $stable(t_r.upd) && $stable(t_r.upd_tgl))
    else $error("update cells changed outside boundary update");

  a_sample_capture: assert property (@(posedge tck) disable iff (!rst_b)
    tap == bst_pkg::bst_st_cap_dr && t_r.ir_cur == `BST_IR_SAMPLE
      |=> t_r.pin_cell_chain[0] == $past(t_r.snap.pin_out[0])
          && t_r.pin_cell_chain[15] == $past(t_r.snap.pin_in[7]))
    else $error("sample does not capture pin states");

  a_upd_copy: assert property (@(posedge clk_sys) disable iff (!rst_b)
    upd_tgl_s != s_r.upd_seen |=> s_r.upd_cp == $past(t_r.upd))
    else $error("update word not taken into system side");

endmodule

// *** bst_sync.sv ***
// two-stage synchroniser
`timescale 1ns/10ps

module bst_sync #(parameter int W = 1)
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bst_sync_st_t;

  bst_sync_st_t st_r;
  bst_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.s2;

endmodule

// *** bst_tap_fsm.sv ***
// test access controller state machine
`timescale 1ns/10ps

module bst_tap_fsm
(
  input  wire logic       tck,
  input  wire logic       rst_b,
  input  wire logic       tms,
  output bst_pkg::bst_tap_t state
);

  typedef struct packed
  {
    bst_pkg::bst_tap_t st;
  } bst_fsm_st_t;

  bst_fsm_st_t f_r;
  bst_fsm_st_t f_nxt;

  always_comb
  begin
    f_nxt = f_r;
    case (f_r.st)
      bst_pkg::bst_st_tlr:    f_nxt.st = tms ? bst_pkg::bst_st_tlr    : bst_pkg::bst_st_rti;
      bst_pkg::bst_st_rti:    f_nxt.st = tms ? bst_pkg::bst_st_sel_dr : bst_pkg::bst_st_rti;
      bst_pkg::bst_st_sel_dr: f_nxt.st = tms ? bst_pkg::bst_st_sel_ir : bst_pkg::bst_st_cap_dr;
      bst_pkg::bst_st_cap_dr: f_nxt.st = tms ? bst_pkg::bst_st_ex1_dr : bst_pkg::bst_st_sh_dr;
      bst_pkg::bst_st_sh_dr:  f_nxt.st = tms ? bst_pkg::bst_st_ex1_dr : bst_pkg::bst_st_sh_dr;
      bst_pkg::bst_st_ex1_dr: f_nxt.st = tms ? bst_pkg::bst_st_upd_dr : bst_pkg::bst_st_pau_dr;
      bst_pkg::bst_st_pau_dr: f_nxt.st = tms ? bst_pkg::bst_st_ex2_dr : bst_pkg::bst_st_pau_dr;
      bst_pkg::bst_st_ex2_dr: f_nxt.st = tms ? bst_pkg::bst_st_upd_dr : bst_pkg::bst_st_sh_dr;
      bst_pkg::bst_st_upd_dr: f_nxt.st = tms ? bst_pkg::bst_st_sel_dr : bst_pkg::bst_st_rti;
      bst_pkg::bst_st_sel_ir: f_nxt.st = tms ? bst_pkg::bst_st_tlr    : bst_pkg::bst_st_cap_ir;
      bst_pkg::bst_st_cap_ir: f_nxt.st = tms ? bst_pkg::bst_st_ex1_ir : bst_pkg::bst_st_sh_ir;
      bst_pkg::bst_st_sh_ir:  f_nxt.st = tms ? bst_pkg::bst_st_ex1_ir : bst_pkg::bst_st_sh_ir;
      bst_pkg::bst_st_ex1_ir: f_nxt.st = tms ? bst_pkg::bst_st_upd_ir : bst_pkg::bst_st_pau_ir;
      bst_pkg::bst_st_pau_ir: f_nxt.st = tms ? bst_pkg::bst_st_ex2_ir : bst_pkg::bst_st_pau_ir;
      bst_pkg::bst_st_ex2_ir: f_nxt.st = tms ? bst_pkg::bst_st_upd_ir : bst_pkg::bst_st_sh_ir;
      bst_pkg::bst_st_upd_ir: f_nxt.st = tms ? bst_pkg::bst_st_sel_dr : bst_pkg::bst_st_rti;
      default:                f_nxt.st = bst_pkg::bst_st_tlr;
    endcase
  end

  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
      f_r <= '{st: bst_pkg::bst_st_tlr};
    else
      f_r <= f_nxt;
  end

  assign state = f_r.st;

endmodule

// *** bst_tester.sv ***
// board tester model driving the scan port
`timescale 1ns/10ps

module bst_tester
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // ---------------------------------------------------------------
  // one test clock period, tdo taken at the rising edge
  // ---------------------------------------------------------------
  task automatic step(input logic m, input logic d, output logic o);
  begin
    tms = m;
    tdi = d;
    #32;
    o = tdo;
    tck = 1'b1;
    #32;
    tck = 1'b0;
  end
  endtask

  // five ones reach test-logic-reset, then idle
  task automatic reset_tap();
    logic o;
  begin
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  end
  endtask

  // ---------------------------------------------------------------
  // ir or dr scan from idle, low bit first, back to idle
  // ---------------------------------------------------------------
  task automatic scan(input bit ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic o;
  begin
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~din[n-1], o);
    // idle clocks let the pin snapshot cross
    for (int i = 0; i < 4; i++)
      step(1'b0, ~din[n-1], o);
  end
  endtask
endmodule

// *** test_boundary_scan_test_port.sv ***
// self-checking bench of the boundary-scan test port
`timescale 1ns/10ps
`include "bst_map.svh"

`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("BAD %s exp %h got %h", nm, e, g); \
    end \
  end

module test_boundary_scan_test_port;
  logic       clk_sys;
  logic       rst_b;
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       tdo;
  logic       tdo_oe;
  logic [7:0] ad_in;
  logic [7:0] ad_out;
  logic [7:0] ad_oe;
  logic [7:0] core_ad_out;
  logic       core_ad_oe;
  logic [7:0] core_ad_in;
  logic       extest_active;
  int         n_mismatch;
  int         compares;

  bst_port dut
  (
    .clk_sys       (clk_sys),
    .rst_b         (rst_b),
    .tck           (tck),
    .tms           (tms),
    .tdi           (tdi),
    .tdo           (tdo),
    .tdo_oe        (tdo_oe),
    .ad_in         (ad_in),
    .ad_out        (ad_out),
    .ad_oe         (ad_oe),
    .core_ad_out   (core_ad_out),
    .core_ad_oe    (core_ad_oe),
    .core_ad_in    (core_ad_in),
    .extest_active (extest_active)
  );

  bst_tester tester
  (
    .tck (tck),
    .tms (tms),
    .tdi (tdi),
    .tdo (tdo)
  );

  initial
    clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // model helpers
  // ---------------------------------------------------------------
  function automatic logic [127:0] rnd128();
    return {$urandom, $urandom, $urandom, $urandom};
  endfunction

  function automatic logic [127:0] cap_exp(logic [7:0] po, logic [7:0] pi, logic nd);
    logic [127:0] e;
  begin
    e = '0;
    for (int k = 0; k < 8; k++)
    begin
      e[2*k]   = po[k];
      e[2*k+1] = pi[k];
    end
    e[16] = nd;
    return e;
  end
  endfunction

  function automatic logic [7:0] ev(logic [127:0] v);
    logic [7:0] r;
  begin
    for (int k = 0; k < 8; k++)
      r[k] = v[2*k];
    return r;
  end
  endfunction

  task automatic drive_pins();
  begin
    @(negedge clk_sys);
    core_ad_out = 8'($urandom);
    core_ad_oe  = 1'($urandom);
    ad_in       = 8'($urandom);
  end
  endtask

  task automatic load_ir(input logic [2:0] code);
    logic [127:0] d;
  begin
    tester.scan(1'b1, 3, {125'h0, code}, d);
    `CHK("ir capture", 3'h1, d[2:0])
  end
  endtask

  task automatic id_scan();
    logic [127:0] d;
  begin
    tester.scan(1'b0, 32, rnd128(), d);
    `CHK("id word", `BST_ID_WORD, d[31:0])
    `CHK("id fields", {`BST_ID_FIXED, `BST_ID_MAKER}, {d[0], d[11:1]})
  end
  endtask

  task automatic test_done();
  begin
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [127:0] dout;
    logic [127:0] din;
    logic [127:0] sp;
    logic [127:0] ep;
    logic [127:0] exp_v;
    logic [2:0]   byp[5];
    logic         q[$];
    int           seed;
    n_mismatch  = 0;
    compares    = 0;
    rst_b       = 1'b0;
    ad_in       = 8'h00;
    core_ad_out = 8'h00;
    core_ad_oe  = 1'b0;
    byp         = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5};
    seed        = $urandom(77707);
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys) rst_b = 1'b1;
    `CHK("tdo_oe idle", 1'b0, tdo_oe)
    tester.reset_tap();
    id_scan();
    // bypass and unlisted codes: one stage, captures zero
    foreach (byp[j])
    begin
      load_ir(byp[j]);
      din = rnd128();
      tester.scan(1'b0, 17, din, dout);
      q = {1'b0};
      for (int i = 0; i < 16; i++)
        q.push_back(din[i]);
      for (int i = 0; i < 17; i++)
        exp_v[i] = q[i];
      `CHK("bypass", exp_v[16:0], dout[16:0])
    end
    // sample/preload keeps the core path
    drive_pins();
    load_ir(`BST_IR_SAMPLE);
    sp = rnd128();
    tester.scan(1'b0, 98, sp, dout);
    exp_v = cap_exp(core_ad_out, ad_in, ~core_ad_oe);
    `CHK("sample cap", exp_v[97:0], dout[97:0])
    `CHK("sample out", core_ad_out, ad_out)
    `CHK("sample oe", {8{core_ad_oe}}, ad_oe)
    `CHK("sample mode", 1'b0, extest_active)
    `CHK("core in", ad_in, core_ad_in)
    `CHK("tdo_oe rest", 1'b0, tdo_oe)
    // external test drives the preloaded pattern
    drive_pins();
    load_ir(`BST_IR_EXTEST);
    `CHK("extest mode", 1'b1, extest_active)
    `CHK("preload out", ev(sp), ad_out)
    `CHK("preload oe", {8{~sp[16]}}, ad_oe)
    ep = rnd128();
    tester.scan(1'b0, 98, ep, dout);
    exp_v = cap_exp(ev(sp), ad_in, sp[16]);
    `CHK("extest cap", exp_v[97:0], dout[97:0])
    `CHK("extest out", ev(ep), ad_out)
    `CHK("extest oe", {8{~ep[16]}}, ad_oe)
    // an id scan leaves the update cells alone
    load_ir(`BST_IR_IDCODE);
    id_scan();
    `CHK("core out", core_ad_out, ad_out)
    load_ir(`BST_IR_EXTEST);
    `CHK("held out", ev(ep), ad_out)
    load_ir(`BST_IR_BYPASS);
    `CHK("left extest", 1'b0, extest_active)
    test_done();
  end
endmodule
